// [inc/pmt_pkg.sv]
// Constants, types and field layout for the wakeup and power-down control block.
// Function
// - Pointer reset write returns filter pointer to zero
// - Pointer reset bit clears itself after one cycle
// - Global unicast makes filtered unicast frames wake frames
// - Wake frame event sets wake-frame-received flag
// - Control register read clears both received flags
// - Magic packet event sets magic-received flag
// - Wake frames wake only when wake enable set
// - Magic packets wake only when magic enable set
// - Power-down discards frames until enabled wake event
// - Wake event clears power-down by hardware
// - Software may clear power-down early
// - Frames forwarded again once power-down is clear
// - Interrupt status follows the two received flags
// - Interrupt mask suppresses the interrupt output
package wake_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // Byte addresses of the registers.
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_DOWN_CLEAR = 4'hC;

    // Field positions in the control and status register.
    localparam int BIT_PTR_RST = 31;
    localparam int BIT_UNI_WAKE = 9;
    localparam int BIT_WAKE_RCVD = 6;
    localparam int BIT_MAGIC_RCVD = 5;
    localparam int BIT_WAKE_EN = 2;
    localparam int BIT_MAGIC_EN = 1;
    localparam int BIT_POWER_DOWN = 0;

    // Field positions in the interrupt status, mask and clear registers.
    localparam int BIT_IRQ_STAT = 3;
    localparam int BIT_IRQ_MASK = 3;
    localparam int BIT_DOWN_CLR = 0;

    // Wakeup filter register pointer.
    localparam int PTR_W = 3;
    localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;
    localparam logic [PTR_W-1:0] PTR_STEP = 3'h1;

    // Receive data path width.
    localparam int RX_W = 8;

    // Power state of the receiver.
    typedef enum logic {
        PM_ACTIVE = 1'b0,
        PM_DOWN = 1'b1
    } pm_state_t;

endpackage

// [core/rx_frame_gate.sv]
// Receive frame gate that drops whole frames that start while the receiver is powered down.
`timescale 1ns/1ps
`default_nettype none
module rx_frame_gate
    import wake_pkg::*;
#(
    parameter int W = RX_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_down,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    input wire logic in_sof,
    input wire logic in_eof,
    output logic out_valid,
    output logic [W-1:0] out_data,
    output logic out_sof,
    output logic out_eof
);

    // Drop decision held from the frame start to its end.
    logic hold_drop;

    // The decision for the current beat: a start takes it fresh, else it is held.
    wire start_beat = in_valid && in_sof;
    wire drop_now = start_beat ? power_down : hold_drop;
    wire pass_beat = in_valid && !drop_now;

    ////////////////////////////////////////////////////////////////////////////

    // Latch the decision at each start so a frame is never cut in half.
    always_ff @(posedge clk) begin
        if (reset) begin
            hold_drop <= 1'b0;
        end else if (start_beat) begin
            hold_drop <= power_down;
        end
    end

    // Register the forwarded beat; dropped beats leave valid low.
    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
            out_sof <= 1'b0;
            out_eof <= 1'b0;
        end else begin
            out_valid <= pass_beat;
            out_data <= in_data;
            out_sof <= pass_beat && in_sof;
            out_eof <= pass_beat && in_eof;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // A frame that starts in power-down never reaches the application.
    drop_start_a: assert property (@(posedge clk) disable iff (reset)
        (start_beat && power_down) |=> !out_valid)
        else $error("Frame started in power-down was forwarded.");

    // A frame that starts with power-down clear is forwarded.
    pass_start_a: assert property (@(posedge clk) disable iff (reset)
        (start_beat && !power_down) |=> (out_valid && out_sof))
        else $error("Frame started outside power-down was dropped.");

endmodule
`default_nettype wire

// [core/pmt_ctrl.sv]
// Wakeup and power-down control with its registers, interrupt and frame gate.
`timescale 1ns/1ps
`default_nettype none
module mac_wakeup_power_down_control
    import wake_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [DATA_W-1:0] RDATA,
    input wire logic RX_FRAME_END,
    input wire logic RX_MAGIC,
    input wire logic RX_WAKE_MATCH,
    input wire logic RX_UNICAST_PASS,
    input wire logic RX_IN_VALID,
    input wire logic [RX_W-1:0] RX_IN_DATA,
    input wire logic RX_IN_SOF,
    input wire logic RX_IN_EOF,
    output logic RX_OUT_VALID,
    output logic [RX_W-1:0] RX_OUT_DATA,
    output logic RX_OUT_SOF,
    output logic RX_OUT_EOF,
    input wire logic FILTER_ACCESS,
    output logic [PTR_W-1:0] FILTER_PTR,
    output logic POWER_DOWN,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage.

    // Power state; the power-down control bit reads from it.
    pm_state_t state;
    pm_state_t next_state;

    // Wake source enables written by software.
    logic magic_packet_enable;
    logic wake_frame_enable;
    logic global_unicast_wake;

    // Sticky received flags, cleared by a read of the control register.
    logic magic_packet_received;
    logic wake_frame_received;

    // Self-clearing pointer reset bit, high for one cycle after its write.
    logic wake_filter_pointer_reset;

    // Interrupt mask bit.
    logic power_mgmt_irq_mask;

    // Wakeup filter register pointer.
    logic [PTR_W-1:0] filter_ptr;

    // Read data word for the cycle after a read.
    logic [DATA_W-1:0] read_word;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    // Strobes for writes of control, mask and clear, and for a control read.
    wire wr_ctrl = WR && (ADDR == ADDR_CTRL);
    wire wr_mask = WR && (ADDR == ADDR_IRQ_MASK);
    wire wr_down_clear = WR && (ADDR == ADDR_DOWN_CLEAR);
    wire rd_ctrl = RD && (ADDR == ADDR_CTRL);

    // Writes of one to the set-only controls; zero bits are ignored.
    wire set_ptr_rst = wr_ctrl && WDATA[BIT_PTR_RST];
    wire set_down = wr_ctrl && WDATA[BIT_POWER_DOWN];
    wire clr_down = wr_down_clear && WDATA[BIT_DOWN_CLR];

    ////////////////////////////////////////////////////////////////////////////
    // Wake detection.

    wire powered_down = (state == PM_DOWN);

    // A filtered unicast frame counts as a wake frame when enabled.
    wire wake_frame = RX_WAKE_MATCH || (global_unicast_wake && RX_UNICAST_PASS);

    // Events only count at a frame end while powered down and enabled.
    wire magic_ev = powered_down && RX_FRAME_END && RX_MAGIC
        && magic_packet_enable;
    wire wake_ev = powered_down && RX_FRAME_END && wake_frame
        && wake_frame_enable;
    // Both sources may fire in one frame; either one ends power-down.
    wire any_ev = magic_ev || wake_ev;

    // Interrupt status is high while either received flag stands.
    wire power_mgmt_irq_status = magic_packet_received || wake_frame_received;

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine.

    // A wake event or a software clear ends power-down; a set enters it.
    // A clear and a wake event in one cycle both lead out of power-down.
    always_comb begin
        next_state = state;
        case (state)
            PM_ACTIVE: begin
                if (set_down) begin
                    next_state = PM_DOWN;
                end
            end
            PM_DOWN: begin
                if (any_ev) begin
                    next_state = PM_ACTIVE;
                end else if (clr_down) begin
                    next_state = PM_ACTIVE;
                end
            end
            default: begin
                next_state = PM_ACTIVE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= PM_ACTIVE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control fields written by software.

    // Enables and mask take the written value.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            magic_packet_enable <= 1'b0;
            wake_frame_enable <= 1'b0;
            global_unicast_wake <= 1'b0;
            power_mgmt_irq_mask <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                magic_packet_enable <= WDATA[BIT_MAGIC_EN];
                wake_frame_enable <= WDATA[BIT_WAKE_EN];
                global_unicast_wake <= WDATA[BIT_UNI_WAKE];
            end
            if (wr_mask) begin
                power_mgmt_irq_mask <= WDATA[BIT_IRQ_MASK];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received flags.

    // An event in the cycle of a read wins over the read clear.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            magic_packet_received <= 1'b0;
            wake_frame_received <= 1'b0;
        end else begin
            if (magic_ev) begin
                magic_packet_received <= 1'b1;
            end else if (rd_ctrl) begin
                magic_packet_received <= 1'b0;
            end
            if (wake_ev) begin
                wake_frame_received <= 1'b1;
            end else if (rd_ctrl) begin
                wake_frame_received <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filter pointer.

    // The reset bit stands for one cycle and then drops by itself.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wake_filter_pointer_reset <= 1'b0;
        end else begin
            wake_filter_pointer_reset <= set_ptr_rst;
        end
    end

    // The pointer steps on each filter access and wraps; a reset write zeroes it.
    // A reset write in the cycle of an access wins, so the next access uses word zero.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            filter_ptr <= PTR_ZERO;
        end else if (set_ptr_rst) begin
            filter_ptr <= PTR_ZERO;
        end else if (FILTER_ACCESS) begin
            filter_ptr <= filter_ptr + PTR_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Assemble the control word; reserved bits read as zero.
    // Unmapped addresses fall through every branch and read zero.
    always_comb begin
        read_word = ZERO_WORD;
        if (ADDR == ADDR_CTRL) begin
            read_word[BIT_PTR_RST] = wake_filter_pointer_reset;
            read_word[BIT_UNI_WAKE] = global_unicast_wake;
            read_word[BIT_WAKE_RCVD] = wake_frame_received;
            read_word[BIT_MAGIC_RCVD] = magic_packet_received;
            read_word[BIT_WAKE_EN] = wake_frame_enable;
            read_word[BIT_MAGIC_EN] = magic_packet_enable;
            read_word[BIT_POWER_DOWN] = powered_down;
        end else if (ADDR == ADDR_IRQ_STAT) begin
            read_word[BIT_IRQ_STAT] = power_mgmt_irq_status;
        end else if (ADDR == ADDR_IRQ_MASK) begin
            read_word[BIT_IRQ_MASK] = power_mgmt_irq_mask;
        end
    end

    // Data stand only in the cycle after the read; otherwise zero.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            RDATA <= ZERO_WORD;
        end else begin
            RDATA <= RD ? read_word : ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign FILTER_PTR = filter_ptr;
    assign POWER_DOWN = powered_down;
    assign IRQ = power_mgmt_irq_status && !power_mgmt_irq_mask;

    // The gate drops frames that start while powered down.
    // The waking frame itself started in power-down, so it is dropped whole.
    rx_frame_gate #(
        .W(RX_W)
    ) rx_frame_gate_inst (
        .clk(CLK_SYS),
        .reset(RESET),
        .power_down(powered_down),
        .in_valid(RX_IN_VALID),
        .in_data(RX_IN_DATA),
        .in_sof(RX_IN_SOF),
        .in_eof(RX_IN_EOF),
        .out_valid(RX_OUT_VALID),
        .out_data(RX_OUT_DATA),
        .out_sof(RX_OUT_SOF),
        .out_eof(RX_OUT_EOF)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    // Every check is idle while reset is high.

    // Write of the pointer reset followed by its one-cycle readback bit.
    sequence ptr_rst_write_s;
        set_ptr_rst;
    endsequence

    sequence ptr_rst_pulse_s;
        wake_filter_pointer_reset ##1 !wake_filter_pointer_reset;
    endsequence

    // Pointer reset bit is a single-cycle pulse.
    ptr_rst_pulse_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ptr_rst_write_s |=> ptr_rst_pulse_s)
        else $error("Pointer reset bit did not clear after one cycle.");

    // Pointer reads zero right after the reset write.
    ptr_zero_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ptr_rst_write_s |=> (FILTER_PTR == PTR_ZERO))
        else $error("Filter pointer not zero after reset write.");

    // Magic packet flag rises after an enabled magic event.
    magic_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        magic_ev |=> magic_packet_received)
        else $error("Magic flag missing after magic event.");

    // Wake frame flag rises after an enabled wake event.
    wake_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        wake_ev |=> wake_frame_received)
        else $error("Wake flag missing after wake event.");

    // A filtered unicast frame wakes when unicast wake and the wake enable are both on.
    unicast_wake_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (powered_down && RX_FRAME_END && RX_UNICAST_PASS && global_unicast_wake
            && wake_frame_enable) |=> (wake_frame_received && !POWER_DOWN))
        else $error("Unicast frame did not wake the receiver.");

    // Without the wake enable the wake flag cannot rise.
    wake_gate_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!wake_frame_enable && !wake_frame_received) |=> !wake_frame_received)
        else $error("Wake flag rose with wake frames disabled.");

    // Without the magic enable the magic flag cannot rise.
    magic_gate_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!magic_packet_enable && !magic_packet_received) |=> !magic_packet_received)
        else $error("Magic flag rose with magic packets disabled.");

    // A read with no event clears both flags and the status.
    read_clear_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (rd_ctrl && !any_ev) |=> (!magic_packet_received && !wake_frame_received
            && !power_mgmt_irq_status))
        else $error("Received flags survived a control read.");

    // Any wake event ends power-down on the next cycle and raises status.
    wake_exit_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        any_ev |=> (!POWER_DOWN && power_mgmt_irq_status))
        else $error("Power-down not left after wake event.");

    // A software clear ends power-down on the next cycle.
    sw_exit_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (powered_down && clr_down) |=> !POWER_DOWN)
        else $error("Software clear did not leave power-down.");

    // A zero write to the power-down bit keeps power-down held.
    zero_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (powered_down && wr_ctrl && !WDATA[BIT_POWER_DOWN] && !any_ev && !clr_down)
            |=> POWER_DOWN)
        else $error("Zero write changed the power-down bit.");

    // The mask holds the interrupt low; unmasked status drives it high.
    irq_mask_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (power_mgmt_irq_mask |-> !IRQ)
            and ((!power_mgmt_irq_mask && power_mgmt_irq_status) |-> IRQ))
        else $error("Interrupt output disagrees with mask and status.");

    // A zero in the pointer reset bit leaves its readback bit low.
    ptr_keep_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (wr_ctrl && !WDATA[BIT_PTR_RST]) |=> !wake_filter_pointer_reset)
        else $error("Zero write raised the pointer reset bit.");

    // Power-down is only entered through a write of one.
    stay_awake_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!powered_down && !set_down) |=> !POWER_DOWN)
        else $error("Power-down entered without a write of one.");

    // Frames outside power-down raise no status.
    awake_quiet_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!powered_down && !power_mgmt_irq_status) |=> !power_mgmt_irq_status)
        else $error("Status rose outside power-down.");

endmodule
`default_nettype wire

// [dv/pmt_station.sv]
// Remote station model that sends receive frames and their end-of-frame flags.
`timescale 1ns/1ps
`default_nettype none
module wake_station
    import wake_pkg::*;
(
    input wire logic clk,
    output logic in_valid,
    output logic [RX_W-1:0] in_data,
    output logic in_sof,
    output logic in_eof,
    output logic frame_end,
    output logic magic,
    output logic wake,
    output logic uni
);
    // Lines start idle so nothing is taken before the first frame.
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_sof = 1'b0;
        in_eof = 1'b0;
        frame_end = 1'b0;
        magic = 1'b0;
        wake = 1'b0;
        uni = 1'b0;
    end

    // Sends one frame of n beats; the kind flags take the given values only at the last beat.
    // Outside that beat the flags show inverted values, never a kind default; the data are inverted only after the frame.
    // It returns at the edge that samples the last beat.
    task automatic send_frame(input int n, input logic m, input logic w, input logic u);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            in_valid <= 1'b1;
            in_data <= 8'hA0 + i[7:0];
            in_sof <= (i == 0);
            in_eof <= (i == n - 1);
            frame_end <= (i == n - 1);
            magic <= (i == n - 1) ? m : ~m;
            wake <= (i == n - 1) ? w : ~w;
            uni <= (i == n - 1) ? u : ~u;
        end
        @(posedge clk);
        in_valid <= 1'b0;
        in_sof <= 1'b0;
        in_eof <= 1'b0;
        frame_end <= 1'b0;
        in_data <= ~in_data;
        magic <= ~m;
        wake <= ~w;
        uni <= ~u;
    endtask
endmodule
`default_nettype wire

// [dv/pmt_ctrl_bench.sv]
// Self-checking bench for the wakeup and power-down control block.
`timescale 1ns/1ps
`default_nettype none
module mac_wakeup_power_down_control_bench
    import wake_pkg::*;
;
    logic clk_sys = 1'b0; // System clock, 5 ns period.
    logic reset = 1'b1; // Synchronous reset, active high.
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic filt_acc = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic frame_end, magic, wake, uni, in_valid, in_sof, in_eof;
    logic [RX_W-1:0] in_data, out_data;
    logic out_valid, out_sof, out_eof, power_down, irq;
    logic [PTR_W-1:0] filt_ptr;
    int error_cnt = 0;
    int samples_checked = 0;
    int fwd = 0; // Forwarded beats seen so far.
    int cycles = 0;
    logic [DATA_W-1:0] d;

    ////////////////////////////////////////////////////////////////////////
    // The clock toggles every half period.
    always #2.5 clk_sys = ~clk_sys;

    mac_wakeup_power_down_control mac_wakeup_power_down_control_inst (.CLK_SYS(clk_sys),
        .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .RX_FRAME_END(frame_end), .RX_MAGIC(magic), .RX_WAKE_MATCH(wake),
        .RX_UNICAST_PASS(uni), .RX_IN_VALID(in_valid), .RX_IN_DATA(in_data),
        .RX_IN_SOF(in_sof), .RX_IN_EOF(in_eof), .RX_OUT_VALID(out_valid),
        .RX_OUT_DATA(out_data), .RX_OUT_SOF(out_sof), .RX_OUT_EOF(out_eof),
        .FILTER_ACCESS(filt_acc), .FILTER_PTR(filt_ptr), .POWER_DOWN(power_down), .IRQ(irq));

    wake_station wake_station_inst (.clk(clk_sys), .in_valid(in_valid), .in_data(in_data),
        .in_sof(in_sof), .in_eof(in_eof), .frame_end(frame_end), .magic(magic),
        .wake(wake), .uni(uni));

    // Counts beats that reach the application side and checks each one.
    // Only three-beat frames are ever forwarded, so the beat index is fwd modulo 3.
    always @(posedge clk_sys) begin
        if (out_valid === 1'b1) begin
            fwd <= fwd + 1;
            chk32({24'h00_0000, out_data}, 32'h0000_00A0 + fwd % 3);
            chk1(out_sof, fwd % 3 == 0);
            chk1(out_eof, fwd % 3 == 2);
        end
    end

    // A hang is cut short after a fixed number of cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares a register word.
    task automatic chk32(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    // Compares a single output line.
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: line %b, expected %b", $time, got, exp);
        end
    endtask

    // Moves to just after the next rising edge.
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    // Bus tasks are entered just after an edge, so strobes may run back to back.
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask

    // Read data are taken in the single cycle after the strobe.
    task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Enters power-down with the given enables, sends a frame in power-down and one after, and checks the outcome.
    task automatic run_case(input logic [DATA_W-1:0] en, input logic mask, input logic m,
        input logic w, input logic u, input logic woken, input logic [DATA_W-1:0] flags);
        int f0;
        bus_write(ADDR_IRQ_MASK, mask ? 32'h0000_0008 : 32'h0000_0000);
        bus_write(ADDR_CTRL, en | 32'h0000_0001);
        bus_write(ADDR_CTRL, en);
        chk1(power_down, 1'b1);
        f0 = fwd;
        wake_station_inst.send_frame(4, m, w, u);
        #1;
        chk1(power_down, ~woken);
        chk1(irq, woken & ~mask);
        tick();
        tick();
        chk32(fwd - f0, 0);
        bus_write(ADDR_DOWN_CLEAR, 32'h0000_0001);
        chk1(power_down, 1'b0);
        bus_read(ADDR_IRQ_STAT, d);
        chk32(d, woken ? 32'h0000_0008 : 32'h0000_0000);
        bus_read(ADDR_CTRL, d);
        chk32(d, en | flags);
        bus_read(ADDR_CTRL, d);
        chk32(d, en);
        chk1(irq, 1'b0);
        f0 = fwd;
        wake_station_inst.send_frame(3, m, w, u);
        tick();
        tick();
        chk32(fwd - f0, 3);
        bus_write(ADDR_CTRL, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        tick();
        chk1(power_down, 1'b0);
        chk1(irq, 1'b0);
        chk32({29'h0, filt_ptr}, 32'h0000_0000);
        // Reset values, reserved bits and an unmapped address.
        bus_read(ADDR_CTRL, d);
        chk32(d, 32'h0000_0000);
        bus_write(ADDR_CTRL, 32'h7FFF_FD98);
        bus_write(4'h2, 32'hFFFF_FFFF);
        bus_write(ADDR_IRQ_MASK, 32'hFFFF_FFFF);
        bus_write(ADDR_IRQ_STAT, 32'hFFFF_FFFF);
        bus_read(ADDR_CTRL, d);
        chk32(d, 32'h0000_0000);
        bus_read(4'h2, d);
        chk32(d, 32'h0000_0000);
        bus_read(ADDR_IRQ_MASK, d);
        chk32(d, 32'h0000_0008);
        tick();
        chk32(rdata, 32'h0000_0000);
        bus_read(ADDR_IRQ_STAT, d);
        chk32(d, 32'h0000_0000);
        bus_read(ADDR_DOWN_CLEAR, d);
        chk32(d, 32'h0000_0000);
        // Filter pointer steps, then a zero write leaves it and a one write clears it.
        filt_acc <= 1'b1;
        repeat (3) tick();
        filt_acc <= 1'b0;
        chk32({29'h0, filt_ptr}, 32'h0000_0003);
        bus_write(ADDR_CTRL, 32'h0000_0000);
        chk32({29'h0, filt_ptr}, 32'h0000_0003);
        bus_write(ADDR_CTRL, 32'h8000_0000);
        chk32({29'h0, filt_ptr}, 32'h0000_0000);
        bus_read(ADDR_CTRL, d);
        chk32(d, 32'h8000_0000);
        bus_read(ADDR_CTRL, d);
        chk32(d, 32'h0000_0000);
        // Wake sources, enables and the mask.
        run_case(32'h0000_0002, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0020);
        run_case(32'h0000_0004, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_0040);
        run_case(32'h0000_0204, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0040);
        run_case(32'h0000_0004, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
        run_case(32'h0000_0002, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0000);
        run_case(32'h0000_0202, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_0000);
        run_case(32'h0000_0006, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 32'h0000_0060);
        end_sim();
    end
endmodule
`default_nettype wire
